/* design/prsd_pkg.sv */
// Package: constants and types for the paged register space decoder
package prsd_pkg;

  localparam logic [7:0] SPACE_LO        = 8'h80;
  localparam logic [7:0] SPACE_HI        = 8'hff;
  localparam logic [7:0] WINDOW_SEL_ADDR = 8'ha7;
  localparam logic [7:0] WINDOW_SEL_RST  = 8'h00;
  localparam logic [7:0] PAGE_ZERO      = 8'h00;
  localparam logic [7:0] PAGE_F         = 8'h0f;
  localparam logic [7:0] ADDR_C5        = 8'hc5;
  localparam logic [7:0] ADDR_97        = 8'h97;
  localparam logic [7:0] ADDR_E6        = 8'he6;
  localparam logic [2:0] BIT_ADDR_MASK  = 3'h0;

  // Decoded target kinds
  typedef enum logic [1:0] {
    PRSD_TGT_NONE,
    PRSD_TGT_SELECT,
    PRSD_TGT_PERIPH
  } prsd_tgt_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       rd;
    logic       wr;
    logic [7:0] wdata;
  } prsd_req_t;

  typedef struct packed {
    logic [7:0] window_sel_q;
    logic [7:0] rdata_q;
    logic       rvalid_q;
    logic       sel_p0_q;
    logic       sel_pf_q;
    logic       sel_all_q;
    logic       hit_q;
    logic       bit_addr_q;
    logic [7:0] addr_q;
  } prsd_state_t;

endpackage : prsd_pkg

/* design/prsd_page_map.sv */
// Per-address page map lookup
`timescale 1ns/1ps
module prsd_page_map
  import prsd_pkg::*;
(
  input  wire logic [7:0] addr_i,
  output logic            on_all_o,
  output logic            on_p0_o,
  output logic            on_pf_o
);

  logic [127:0] all_map;
  logic [127:0] p0_map;
  logic [127:0] pf_map;
  logic [6:0]   idx;

  // Presence bitmaps over 0x80..0xff, bit n = address 0x80+n
  assign all_map = 128'h0001_01c1_0102_0000_01cd_1101_0001_400d;
  assign p0_map  = 128'h1818_1e06_0000_0078_6800_2600_fcc0_0000;
  assign pf_map  = 128'h7efe_5010_0670_c0f2_f020_8670_9cfe_0000;
  assign idx     = addr_i[6:0];

  always_comb begin
    on_all_o = all_map[idx];
    on_p0_o  = p0_map[idx] | (addr_i == ADDR_C5) | (addr_i == ADDR_97);
    on_pf_o  = pf_map[idx] | (addr_i == ADDR_C5) | (addr_i == ADDR_97);
  end

endmodule : prsd_page_map

/* design/prsd_top.sv */
// Paged register space decoder with window select register
`timescale 1ns/1ps
module prsd_top
  import prsd_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic       rd_i,
  input  wire logic       wr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic [7:0] periph_rdata_i,
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  output logic [7:0]      window_sel_o,
  output logic            sel_p0_o,
  output logic            sel_pf_o,
  output logic            sel_all_o,
  output logic            hit_o,
  output logic            bit_addr_o,
  output logic [7:0]      periph_addr_o
);

  prsd_state_t s_q;
  prsd_state_t s_d;
  prsd_req_t   req;
  prsd_tgt_t   tgt;
  logic        on_all;
  logic        on_p0;
  logic        on_pf;
  logic        in_space;
  logic        page0;
  logic        pagef;

  assign req = '{addr: addr_i, rd: rd_i, wr: wr_i, wdata: wdata_i};

  prsd_page_map i_prsd_page_map (
    .addr_i   (req.addr),
    .on_all_o (on_all),
    .on_p0_o  (on_p0),
    .on_pf_o  (on_pf)
  );

  always_comb begin
    in_space = (req.addr >= SPACE_LO) && (req.addr <= SPACE_HI);
    page0    = (s_q.window_sel_q == PAGE_ZERO);
    pagef    = (s_q.window_sel_q == PAGE_F);
    tgt      = PRSD_TGT_NONE;
    if (in_space && req.addr == WINDOW_SEL_ADDR) begin
      tgt = PRSD_TGT_SELECT;
    end else if (in_space && (on_all || (page0 && on_p0) || (pagef && on_pf))) begin
      tgt = PRSD_TGT_PERIPH;
    end
  end

  always_comb begin
    s_d            = s_q;
    s_d.rvalid_q   = 1'b0;
    s_d.addr_q     = req.addr;
    s_d.sel_all_q  = 1'b0;
    s_d.sel_p0_q   = 1'b0;
    s_d.sel_pf_q   = 1'b0;
    s_d.hit_q      = 1'b0;
    s_d.bit_addr_q = in_space && (req.addr[2:0] == BIT_ADDR_MASK);
    case (tgt)
      PRSD_TGT_SELECT: begin
        s_d.hit_q = req.rd | req.wr;
        if (req.wr) begin
          s_d.window_sel_q = req.wdata;
        end
        if (req.rd) begin
          s_d.rdata_q  = s_q.window_sel_q;
          s_d.rvalid_q = 1'b1;
        end
      end
      PRSD_TGT_PERIPH: begin
        s_d.hit_q     = req.rd | req.wr;
        s_d.sel_all_q = on_all & (req.rd | req.wr);
        s_d.sel_p0_q  = ~on_all & page0 & (req.rd | req.wr);
        s_d.sel_pf_q  = ~on_all & pagef & (req.rd | req.wr);
        if (req.rd) begin
          s_d.rdata_q  = periph_rdata_i;
          s_d.rvalid_q = 1'b1;
        end
      end
      PRSD_TGT_NONE: begin
        if (req.rd) begin
          s_d.rdata_q  = 8'h00;
          s_d.rvalid_q = 1'b1;
        end
      end
      default: begin
        s_d = s_q;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q              <= '0;
      s_q.window_sel_q <= WINDOW_SEL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o       = s_q.rdata_q;
  assign rvalid_o      = s_q.rvalid_q;
  assign window_sel_o  = s_q.window_sel_q;
  assign sel_p0_o      = s_q.sel_p0_q;
  assign sel_pf_o      = s_q.sel_pf_q;
  assign sel_all_o     = s_q.sel_all_q;
  assign hit_o         = s_q.hit_q;
  assign bit_addr_o    = s_q.bit_addr_q;
  assign periph_addr_o = s_q.addr_q;

endmodule : prsd_top

/* tb/prsd_props.sv */
// Checker for the paged register space decoder
`timescale 1ns/1ps
module prsd_props
  import prsd_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic [7:0] addr_i,
  input wire logic       rd_i,
  input wire logic       wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] periph_rdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic       rvalid_o,
  input wire logic [7:0] window_sel_o,
  input wire logic       sel_p0_o,
  input wire logic       sel_pf_o,
  input wire logic       sel_all_o,
  input wire logic       hit_o,
  input wire logic       bit_addr_o,
  input wire logic [7:0] periph_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  AST_RVALID: assert property (rd_i |=> rvalid_o) else $error("no read valid");
  AST_SEL_WR: assert property (wr_i && addr_i == WINDOW_SEL_ADDR |=> window_sel_o == $past(wdata_i))
    else $error("select not written");
  AST_SEL_RD: assert property (rd_i && !wr_i && addr_i == WINDOW_SEL_ADDR |=> rdata_o == $past(window_sel_o))
    else $error("select read wrong");
  AST_PF_C5: assert property (rd_i && addr_i == ADDR_C5 && window_sel_o == PAGE_F
    |=> sel_pf_o && rdata_o == $past(periph_rdata_i)) else $error("page F decode wrong");
  AST_P0_97: assert property (rd_i && addr_i == ADDR_97 && window_sel_o == PAGE_ZERO |=> sel_p0_o && hit_o)
    else $error("page 0 decode wrong");
  AST_ALL_E6: assert property ((rd_i || wr_i) && addr_i == ADDR_E6 |=> sel_all_o && hit_o)
    else $error("all pages decode wrong");
  AST_BAD_PG: assert property (rd_i && addr_i == ADDR_C5 && window_sel_o == 8'h05 |=> !hit_o && rdata_o == 8'h00)
    else $error("bad page responded");
  AST_BIT_ADDR: assert property (##1 bit_addr_o == ($past(addr_i[7]) && $past(addr_i[2:0]) == BIT_ADDR_MASK))
    else $error("bit address flag wrong");
  AST_PADDR: assert property (##1 periph_addr_o == $past(addr_i))
    else $error("address copy wrong");
endmodule : prsd_props

/* tb/prsd_core.sv */
// Core model issuing register accesses
`timescale 1ns/1ps
module prsd_core (
  input  wire logic       core_clk_i,
  output logic [7:0]      addr_o,
  output logic            rd_o,
  output logic            wr_o,
  output logic [7:0]      wdata_o
);
  initial {addr_o, rd_o, wr_o, wdata_o} = 18'h0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= !w;
    wr_o <= w;
    wdata_o <= d;
    @(posedge core_clk_i);
    {rd_o, wr_o} <= 2'h0;
    addr_o <= ~a;
    wdata_o <= ~d;
    #1;
  endtask : acc
endmodule : prsd_core

/* tb/prsd_top_test.sv */
// Self-checking bench for the paged register space decoder
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected %0t %h %h", $time, a, e); end end
module prsd_top_test
  import prsd_pkg::*;
;
  logic       clk, rst, rd, wr, rvalid, s0, sf, sa, hit, ba;
  logic [7:0] addr, wdata, rdata, wsel, pr;
  logic [7:0] pg [3] = '{8'h00, 8'h0f, 8'h05};
  int         n_mismatch, tests_run;
  assign pr = addr ^ 8'h5a;
  prsd_core i_prsd_core (.core_clk_i(clk), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
  prsd_top i_prsd_top (.core_clk_i(clk), .rst_i(rst), .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata),
    .periph_rdata_i(pr), .rdata_o(rdata), .rvalid_o(rvalid), .window_sel_o(wsel), .sel_p0_o(s0),
    .sel_pf_o(sf), .sel_all_o(sa), .hit_o(hit), .bit_addr_o(ba), .periph_addr_o());
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    i_prsd_core.acc(1'h1, a, d);
  endtask : wrt
  task automatic rdt(input logic [7:0] a);
    i_prsd_core.acc(1'h0, a, 8'h00);
  endtask : rdt
  task automatic test_done;
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic t_paged;
    wrt(WINDOW_SEL_ADDR, PAGE_F);
    `CHK({hit, wsel}, {1'h1, PAGE_F})
    rdt(ADDR_C5);
    `CHK({rvalid, sf, hit, rdata}, {3'h7, ADDR_C5 ^ 8'h5a})
    rdt(ADDR_97);
    `CHK({s0, sf, hit}, 3'h3)
    wrt(WINDOW_SEL_ADDR, PAGE_ZERO);
    rdt(ADDR_97);
    `CHK({s0, hit, rdata}, {2'h3, ADDR_97 ^ 8'h5a})
    rdt(ADDR_C5);
    `CHK({s0, sf}, 2'h2)
    $display("paged done");
  endtask : t_paged
  task automatic t_all;
    foreach (pg[i]) begin
      wrt(WINDOW_SEL_ADDR, pg[i]);
      rdt(ADDR_E6);
      `CHK({sa, hit}, 2'h3)
      rdt(WINDOW_SEL_ADDR);
      `CHK(rdata, pg[i])
    end
    $display("all pages done");
  endtask : t_all
  task automatic t_bad;
    rdt(ADDR_C5);
    `CHK({hit, rdata}, 9'h0)
    rdt(SPACE_LO);
    `CHK(ba, 1'h1)
    rdt(8'h81);
    `CHK(ba, 1'h0)
    $display("bad page done");
  endtask : t_bad
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end
  initial begin
    rst = 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    #1;
    `CHK(wsel, WINDOW_SEL_RST)
    t_paged();
    t_all();
    t_bad();
    test_done();
  end
endmodule : prsd_top_test
bind prsd_top prsd_props i_prsd_props (.*);
